// ==== verilog/bipp_top.sv ====
// AHB-Lite register front end and port logic of the bidirectional I/O ports
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module bipp_top
   import bipp_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   input wire logic [BIPP_PIN_W-1:0] pin_in,
   output logic [BIPP_PIN_W-1:0] pin_out,
   output logic [BIPP_PIN_W-1:0] pin_oe_n,
   output logic [BIPP_PIN_W-1:0] pin_pullup,
   input wire logic sleep_deep,
   input wire logic [BIPP_PIN_W-1:0] ext_int_enable
);
   logic wr_pend_q;
   logic [31:0] waddr_q;
   logic [BIPP_PIN_W-1:0] dir_q;
   logic [BIPP_PIN_W-1:0] dir_d;
   logic [BIPP_PIN_W-1:0] out_q;
   logic [BIPP_PIN_W-1:0] out_d;
   logic pud_q;
   logic pud_d;
   logic [BIPP_PIN_W-1:0] pin_input_bit;
   logic [BIPP_PIN_W-1:0] clamp;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic [1:0] hresp_q;

   wire addr_phase = hsel && htrans == BIPP_HTRANS_NONSEQ && hready;
   wire rd_take = addr_phase && !hwrite;
   wire wr_take = addr_phase && hwrite;

   // Write decode on the held data-phase address
   wire w_in_ports = wr_pend_q && waddr_q[31:7] == BIPP_PORT_REGION_HI;
   wire [BIPP_PSEL_W-1:0] w_port = waddr_q[BIPP_PSEL_LSB +: BIPP_PSEL_W];
   wire [BIPP_OFS_W-1:0] w_ofs = waddr_q[BIPP_OFS_W-1:0];
   wire w_sfr = wr_pend_q && waddr_q == BIPP_ADDR_SFR;
   wire [BIPP_PORT_W-1:0] wbyte = hwdata[BIPP_PORT_W-1:0];

   // Read decode on the live address phase
   wire r_in_ports = haddr[31:7] == BIPP_PORT_REGION_HI;
   wire [BIPP_PSEL_W-1:0] r_port = haddr[BIPP_PSEL_LSB +: BIPP_PSEL_W];
   wire [BIPP_OFS_W-1:0] r_ofs = haddr[BIPP_OFS_W-1:0];

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_pend_q <= 1'b0;
         waddr_q <= '0;
      end else begin
         wr_pend_q <= wr_take;
         waddr_q <= wr_take ? haddr : waddr_q;
      end
   end

   // Every port takes its write value from the same low byte of the write data, hwdata[7:0]
   genvar p;
   generate
      for (p = 0; p < BIPP_NUM_PORTS; p++) begin : g_port
         wire hit = w_in_ports && w_port == BIPP_PSEL_W'(p);
         wire [BIPP_PORT_W-1:0] dcur = dir_q[p*BIPP_PORT_W +: BIPP_PORT_W];
         wire [BIPP_PORT_W-1:0] ocur = out_q[p*BIPP_PORT_W +: BIPP_PORT_W];
         wire [BIPP_PORT_W-1:0] dnew =
            (hit && w_ofs == BIPP_OFS_DIR) ? wbyte :
            (hit && w_ofs == BIPP_OFS_DIR_SET) ? (dcur | wbyte) :
            (hit && w_ofs == BIPP_OFS_DIR_CLR) ? (dcur & ~wbyte) : dcur;
         wire [BIPP_PORT_W-1:0] onew =
            (hit && w_ofs == BIPP_OFS_OUT) ? wbyte :
            (hit && w_ofs == BIPP_OFS_OUT_SET) ? (ocur | wbyte) :
            (hit && w_ofs == BIPP_OFS_OUT_CLR) ? (ocur & ~wbyte) :
            (hit && w_ofs == BIPP_OFS_OUT_TGL) ? (ocur ^ wbyte) : ocur;
         assign dir_d[p*BIPP_PORT_W +: BIPP_PORT_W] = dnew;
         assign out_d[p*BIPP_PORT_W +: BIPP_PORT_W] = onew;
      end
   endgenerate

   assign pud_d = w_sfr ? hwdata[BIPP_PUD_BIT] : pud_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         dir_q <= {BIPP_NUM_PORTS{BIPP_DIR_RST}};
         out_q <= {BIPP_NUM_PORTS{BIPP_OUT_RST}};
         pud_q <= BIPP_PUD_RST;
      end else begin
         dir_q <= dir_d;
         out_q <= out_d;
         pud_q <= pud_d;
      end
   end

   // Direction, output and SFR reads use next values so a read right after a write sees the new setting
   wire [BIPP_PIN_W-1:0] pin_sh = pin_input_bit >> (r_port * BIPP_PORT_W);
   wire [BIPP_PIN_W-1:0] dir_sh = dir_d >> (r_port * BIPP_PORT_W);
   wire [BIPP_PIN_W-1:0] out_sh = out_d >> (r_port * BIPP_PORT_W);
   wire [BIPP_PORT_W-1:0] r_dir = dir_sh[BIPP_PORT_W-1:0];
   wire [BIPP_PORT_W-1:0] r_out = out_sh[BIPP_PORT_W-1:0];
   wire [BIPP_PORT_W-1:0] r_pin = pin_sh[BIPP_PORT_W-1:0];
   wire [31:0] rdata =
      (r_in_ports && r_ofs == BIPP_OFS_INPUT) ? {24'h000000, r_pin} :
      (r_in_ports && r_ofs == BIPP_OFS_DIR) ? {24'h000000, r_dir} :
      (r_in_ports && r_ofs == BIPP_OFS_OUT) ? {24'h000000, r_out} :
      (haddr == BIPP_ADDR_SFR) ? (32'(pud_d) << BIPP_PUD_BIT) :
      (haddr == BIPP_ADDR_PULL_STAT) ? pin_pullup :
      (haddr == BIPP_ADDR_DRIVE_STAT) ? ~pin_oe_n : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (reset) begin
         hrdata_q <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q <= BIPP_HRESP_OKAY;
      end else begin
         hrdata_q <= rd_take ? rdata : 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q <= BIPP_HRESP_OKAY;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;

   // In deep sleep the input of every pin without ext_int_enable is clamped low; pins with it stay live
   assign clamp = {BIPP_PIN_W{sleep_deep}} & ~ext_int_enable;

   bipp_sync u_sync (
      .clk(clk),
      .reset(reset),
      .pin_raw(pin_in),
      .clamp(clamp),
      .pin_input_bit(pin_input_bit)
   );

   // Pads load the next values so a write reaches the pin at its own edge
   bipp_pad u_pad (
      .clk(clk),
      .reset(reset),
      .dir_d(dir_d),
      .out_d(out_d),
      .pud_d(pud_d),
      .pin_out_q(pin_out),
      .pin_oe_n_q(pin_oe_n),
      .pin_pullup_q(pin_pullup)
   );
endmodule

// ==== verilog/bipp_pkg.sv ====
// Constants shared by the bidirectional I/O port block
package bipp_pkg;
   localparam int unsigned BIPP_PORT_W = 8;
   localparam int unsigned BIPP_NUM_PORTS = 4;
   localparam int unsigned BIPP_PIN_W = BIPP_PORT_W * BIPP_NUM_PORTS;
   // Per-port window: port index in haddr[6:5], register offset in haddr[4:0]
   localparam int unsigned BIPP_OFS_W = 5;
   localparam int unsigned BIPP_PSEL_LSB = 5;
   localparam int unsigned BIPP_PSEL_W = 2;
   localparam logic [4:0] BIPP_OFS_INPUT = 5'h00;
   localparam logic [4:0] BIPP_OFS_DIR = 5'h04;
   localparam logic [4:0] BIPP_OFS_OUT = 5'h08;
   localparam logic [4:0] BIPP_OFS_DIR_SET = 5'h0C;
   localparam logic [4:0] BIPP_OFS_DIR_CLR = 5'h10;
   localparam logic [4:0] BIPP_OFS_OUT_SET = 5'h14;
   localparam logic [4:0] BIPP_OFS_OUT_CLR = 5'h18;
   localparam logic [4:0] BIPP_OFS_OUT_TGL = 5'h1C;
   localparam logic [31:0] BIPP_ADDR_SFR = 32'h0000_0080;
   localparam logic [31:0] BIPP_ADDR_PULL_STAT = 32'h0000_0084;
   localparam logic [31:0] BIPP_ADDR_DRIVE_STAT = 32'h0000_0088;
   localparam logic [24:0] BIPP_PORT_REGION_HI = 25'h000_0000;
   localparam int unsigned BIPP_PUD_BIT = 2;
   localparam logic [7:0] BIPP_DIR_RST = 8'h00;
   localparam logic [7:0] BIPP_OUT_RST = 8'h00;
   localparam logic BIPP_PUD_RST = 1'b0;
   localparam logic [1:0] BIPP_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] BIPP_HRESP_OKAY = 2'h0;
endpackage

// ==== verilog/bipp_sync.sv ====
// Two-stage pin input synchronizer with sleep clamp
`timescale 1ns/1ns
module bipp_sync
   import bipp_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [BIPP_PIN_W-1:0] pin_raw,
   input wire logic [BIPP_PIN_W-1:0] clamp,
   output logic [BIPP_PIN_W-1:0] pin_input_bit
);
   logic [BIPP_PIN_W-1:0] gated;
   logic [BIPP_PIN_W-1:0] latch_q;
   logic [BIPP_PIN_W-1:0] sync_q;

   // Clamp to ground ahead of the synchronizer so a floating pad cannot toggle it
   assign gated = pin_raw & ~clamp;

   // Holds the level present when clk falls, as a latch open during clk high would
   always_ff @(negedge clk) begin
      if (reset) begin
         latch_q <= '0;
      end else begin
         latch_q <= gated;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         sync_q <= '0;
      end else begin
         sync_q <= latch_q;
      end
   end

   assign pin_input_bit = sync_q;
endmodule

// ==== verilog/bipp_pad.sv ====
// Pad drive and pull-up flops, tri-stated asynchronously by reset
`timescale 1ns/1ns
module bipp_pad
   import bipp_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [BIPP_PIN_W-1:0] dir_d,
   input wire logic [BIPP_PIN_W-1:0] out_d,
   input wire logic pud_d,
   output logic [BIPP_PIN_W-1:0] pin_out_q,
   output logic [BIPP_PIN_W-1:0] pin_oe_n_q,
   output logic [BIPP_PIN_W-1:0] pin_pullup_q
);
   logic [BIPP_PIN_W-1:0] pull_d;

   assign pull_d = ~dir_d & out_d & {BIPP_PIN_W{~pud_d}};

   // Asynchronous here only: pads must release even with the clock stopped
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_oe_n_q <= '1;
         pin_out_q <= '0;
         pin_pullup_q <= '0;
      end else begin
         pin_oe_n_q <= ~dir_d;
         pin_out_q <= out_d;
         pin_pullup_q <= pull_d;
      end
   end
endmodule

// ==== tb/bipp_checker.sv ====
// Port-level assertions for the I/O port block
`timescale 1ns/1ns
module bipp_checker
   import bipp_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [1:0] hresp,
   input wire logic [31:0] hrdata,
   input wire logic [BIPP_PIN_W-1:0] pin_out,
   input wire logic [BIPP_PIN_W-1:0] pin_oe_n,
   input wire logic [BIPP_PIN_W-1:0] pin_pullup
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire tk = hsel && htrans == BIPP_HTRANS_NONSEQ && hready;
   wire wr0 = tk && hwrite && haddr[31:5] == 27'h0;
   reset_tristate_a: assert property (disable iff (1'b0) reset |-> &pin_oe_n && pin_pullup == '0)
      else $error("pins active in reset");
   pullup_input_a: assert property ((pin_pullup & ~pin_oe_n) == '0)
      else $error("pull-up on a driven pin");
   dir_write_a: assert property (wr0 && haddr[4:0] == BIPP_OFS_DIR ##1 1 |=> ~pin_oe_n[7:0] == $past(hwdata[7:0]))
      else $error("direction write not applied");
   out_write_a: assert property (wr0 && haddr[4:0] == BIPP_OFS_OUT ##1 1 |=>
      (pin_out[7:0] | pin_oe_n[7:0]) == ($past(hwdata[7:0]) | pin_oe_n[7:0])) else $error("drive level wrong");
   dir_set_a: assert property (wr0 && haddr[4:0] == BIPP_OFS_DIR_SET ##1 1 |=>
      ~pin_oe_n[7:0] == (~$past(pin_oe_n[7:0]) | $past(hwdata[7:0]))) else $error("bit set disturbed pins");
   dir_clr_a: assert property (wr0 && haddr[4:0] == BIPP_OFS_DIR_CLR ##1 1 |=>
      ~pin_oe_n[7:0] == (~$past(pin_oe_n[7:0]) & ~$past(hwdata[7:0]))) else $error("bit clear disturbed pins");
   bus_okay_a: assert property (hreadyout && hresp == BIPP_HRESP_OKAY)
      else $error("bus not ready or not okay");
   rdata_idle_a: assert property (!(tk && !hwrite) |=> hrdata == '0)
      else $error("read data outside data phase");
endmodule

// ==== tb/bipp_board.sv ====
// Board-side model of the pads around the port
`timescale 1ns/1ns
module bipp_board (
   input wire logic clk,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe_n,
   input wire logic [31:0] pin_pullup,
   input wire logic [31:0] ext_en,
   input wire logic [31:0] ext_val,
   output logic [31:0] pin_in
);
   logic flt_q = 1'b0;
   // A floating pad changes every cycle so a stale value never reads as right
   always @(posedge clk) flt_q <= ~flt_q;
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) |
      (pin_oe_n & ~ext_en & (pin_pullup | {32{flt_q}}));
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the I/O port block
`timescale 1ns/1ns
module tb_top;
   import bipp_pkg::*;
   logic clk = 1'b0, reset = 1'b0, hsel = 1'b0, hwrite = 1'b0, sleep_deep = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = '0, hwdata = '0, ext_en = '0, ext_val = '0, ext_int_enable = '0, rd_s;
   wire logic hready;
   wire logic [1:0] hresp;
   wire logic [31:0] hrdata, pin_in, pin_out, pin_oe_n, pin_pullup;
   int fail_count = 0, comparisons = 0;
   always #5 clk = ~clk;
   always @(posedge clk) rd_s <= hrdata;
   bipp_top i_dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
      .sleep_deep(sleep_deep), .ext_int_enable(ext_int_enable));
   bipp_board i_board (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Ends 1 ns after the data phase edge so pad updates have landed
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= BIPP_HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      #1;
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd_s, exp);
   endtask
   task automatic t_reset();
      chk(pin_oe_n, '1);
      chk(pin_pullup, '0);
      rdc(32'h04, 32'h0);
      rdc(32'h08, 32'h0);
   endtask
   task automatic t_drive();
      xfer(1'b1, 32'h04, 32'hFF);
      xfer(1'b1, 32'h08, 32'hA5);
      chk(pin_oe_n, 32'hFFFF_FF00);
      chk(pin_out[7:0], 32'hA5);
      rdc(32'h00, 32'hA5);
   endtask
   task automatic t_bits();
      xfer(1'b1, 32'h10, 32'h0F);
      chk(pin_oe_n, 32'hFFFF_FF0F);
      xfer(1'b1, 32'h0C, 32'h03);
      chk(pin_oe_n, 32'hFFFF_FF0C);
      chk(pin_pullup, 32'h04);
      xfer(1'b1, BIPP_ADDR_SFR, 32'h4);
      chk(pin_pullup, 32'h0);
      rdc(BIPP_ADDR_SFR, 32'h4);
      xfer(1'b1, BIPP_ADDR_SFR, 32'h0);
      chk(pin_pullup, 32'h04);
      rdc(BIPP_ADDR_PULL_STAT, 32'h04);
      rdc(BIPP_ADDR_DRIVE_STAT, 32'hF3);
      xfer(1'b1, 32'h14, 32'h50);
      xfer(1'b1, 32'h18, 32'h81);
      xfer(1'b1, 32'h1C, 32'h0F);
      rdc(32'h08, 32'h7B);
      chk(pin_pullup, 32'h08);
   endtask
   task automatic t_input();
      @(posedge clk);
      ext_en <= 32'hFF00_0000;
      ext_val <= 32'h3C00_0000;
      rdc(32'h60, 32'h3C);
      xfer(1'b1, 32'h60, 32'hFF);
      rdc(32'h60, 32'h3C);
      rdc(32'h8C, 32'h0);
      @(posedge clk);
      sleep_deep <= 1'b1;
      ext_int_enable <= 32'h0400_0000;
      rdc(32'h60, 32'h04);
      @(posedge clk);
      sleep_deep <= 1'b0;
   endtask
   task automatic t_reset2();
      @(posedge clk);
      reset <= 1'b1;
      #1 chk(pin_oe_n, '1);
      chk(pin_pullup, '0);
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rdc(32'h04, 32'h0);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      // Raised at time zero so the asynchronous pad reset sees a real edge
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_drive();
      t_bits();
      t_input();
      t_reset2();
      end_of_test();
   end
   initial begin
      #20000;
      fail_count++;
      end_of_test();
   end
endmodule
bind bipp_top bipp_checker i_chk (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup));
